/* src/ibaf_map.vh */
`ifndef IBAF_MAP_VH
`define IBAF_MAP_VH
// Register byte offsets on the AHB-Lite slave
`define IBAF_CTRL_OFF 8'h00
`define IBAF_STATUS_OFF 8'h04
`define IBAF_CFG_BASE_OFF 8'h08
`define IBAF_RX_LEN_OFF 8'h0C
`define IBAF_TX_LEN_OFF 8'h10
`define IBAF_MODE_OFF 8'h14
`define IBAF_RX_BASE_OFF 8'h18
`define IBAF_TX_BASE_OFF 8'h1C
`define IBAF_STA_LO_OFF 8'h20
`define IBAF_STA_HI_OFF 8'h24
`define IBAF_HASH_LO_OFF 8'h28
`define IBAF_HASH_HI_OFF 8'h2C
`define IBAF_FILT_DA_LO_OFF 8'h30
`define IBAF_FILT_DA_HI_OFF 8'h34
`define IBAF_FILT_RES_OFF 8'h38
// Configuration block word indices (byte offset / 2)
`define IBAF_CB_WORDS 4'hC
`define IBAF_CB_MODE 4'h0
`define IBAF_CB_STA0 4'h1
`define IBAF_CB_STA2 4'h3
`define IBAF_CB_HASH0 4'h4
`define IBAF_CB_HASH3 4'h7
`define IBAF_CB_RXLO 4'h8
`define IBAF_CB_RXHI 4'h9
`define IBAF_CB_TXLO 4'hA
`define IBAF_CB_TXHI 4'hB
// Ring size field position in its word
`define IBAF_SIZE_HI 15
`define IBAF_SIZE_LO 13
// Mode word bits; PROM and DISBC are used by the filter
`define IBAF_MODE_PROM 15
`define IBAF_MODE_DISBC 14
`define IBAF_MODE_TXCRC_DIS 3
// Control register bits
`define IBAF_CTRL_INIT 0
`define IBAF_CTRL_RUN 1
// Reset values
`define IBAF_MODE_RST 16'h0000
`define IBAF_LEN_RST 8'h01
// CRC-32 polynomial, reflected form
`define IBAF_CRC_POLY 32'hEDB88320
`endif

/* src/ibaf_top.v */
// Contract
// R1 - Config block sits on 16-bit word boundary
// R2 - Config words: mode, station, hash, rings
// R3 - Ring size codes are bits 15..13
// R4 - Ring entries equal two to size code
// R5 - Length registers written later override sizes
// R6 - Ring base: low word plus next low byte
// R7 - Ring entries lie on 8-byte boundaries
// R8 - First wire bit one means logical address
// R9 - CRC top six bits select hash bit
// R10 - Zero hash rejects logical except broadcast
// R11 - Broadcast skips hash; disable unless promiscuous
// R12 - Loopback multicast: software moves CRC to receiver
// R13 - Station address 48 bits, individual only
// R14 - Byte n maps to bits 8n-1..8n-8
// R15 - Mode word copied into mode control register
// R16 - Software rechecks multicast against its list
// R17 - Fetch twelve words ascending before enabling
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ibaf_map.vh"
module ibaf_top (
    input wire hclk, // System clock, 200 MHz
    input wire hresetn, // Asynchronous reset, active low
    input wire hsel, // Slave select
    input wire [31:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write when high
    input wire [2:0] hsize, // Transfer size
    input wire [31:0] hwdata, // Write data
    input wire hready, // Bus ready in
    output reg [31:0] hrdata, // Read data
    output wire hreadyout, // Slave ready
    output wire hresp, // Always OKAY
    output reg [23:0] mem_addr, // DMA byte address
    output reg mem_req, // DMA read request, level
    input wire mem_ack, // DMA word returned
    input wire [15:0] mem_rdata, // DMA read word
    output reg init_done, // Setup loaded, level
    output reg rx_enable, // Reception enabled
    output reg tx_enable, // Transmission enabled
    output reg [15:0] mode_control_register, // Mode copy
    output reg [47:0] station_address, // Loaded node address
    output reg [23:0] rx_ring_base, // Receive ring base
    output reg [23:0] tx_ring_base, // Transmit ring base
    output reg [7:0] rx_ring_entries, // Receive ring length
    output reg [7:0] tx_ring_entries, // Transmit ring length
    input wire da_valid, // Destination address strobe
    input wire [47:0] da_addr, // Destination, byte 1 in [7:0]
    output reg filt_valid, // Filter verdict strobe
    output reg filt_accept // Frame accepted
);
    // The block has three jobs: fetch the setup words from host
    // memory, hold the fields they carry, and judge each incoming
    // destination address against those fields.
    // All of it runs on hclk; pin inputs are taken as synchronous,
    // so no synchroniser stage sits in front of them.
    // Fetch machine states, one-hot
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_REQ = 3'b010;
    localparam [2:0] S_DONE = 3'b100;

    // Internal state; the fields not driven out as module outputs,
    // the hash filter and size codes among them, live here.
    reg [2:0] state_reg; // Fetch state
    reg [3:0] word_reg; // Word index being fetched
    reg [23:0] cfg_base_reg; // Config block base
    reg [2:0] rx_ring_size_code; // Receive size code
    reg [2:0] tx_ring_size_code; // Transmit size code
    reg [63:0] multicast_hash_filter; // Hash filter bits
    reg run_reg; // Software enable of rx/tx
    reg [47:0] last_da_reg; // Last address filtered
    reg last_res_reg; // Last verdict
    // AHB data phase capture
    reg wr_pend_reg; // Write data phase pending
    reg [7:0] wr_addr_reg; // Latched write offset

    wire rd_take; // Read address phase accepted
    wire wr_take; // Write address phase accepted
    assign rd_take = hsel & hready & htrans[1] & ~hwrite;
    assign wr_take = hsel & hready & htrans[1] & hwrite;
    // Zero wait states keep the slave simple
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // The hash needs the frame CRC over the six address bytes only.
    // A serial loop is cheap to read; synthesis flattens it into
    // an XOR tree of 48 levels, which at 200 MHz is the longest
    // path in the block. Pipelining it would add a cycle to the
    // verdict, which the strobe timing does not allow.
    // No final inversion: the index uses the raw remainder.
    // CRC-32 over the destination, LSB first as on the wire
    function [31:0] crc_of;
        input [47:0] d;
        integer i;
        reg [31:0] c;
        begin
            c = 32'hFFFFFFFF;
            for (i = 0; i < 48; i = i + 1) begin
                if (c[0] ^ d[i])
                    c = (c >> 1) ^ `IBAF_CRC_POLY;
                else
                    c = c >> 1;
            end
            crc_of = c;
        end
    endfunction

    // Two to the size code, as an entry count
    function [7:0] ent_of;
        input [2:0] code;
        begin
            ent_of = 8'h01 << code; // R4
        end
    endfunction

    // Priority of the filter tests matters:
    // broadcast first, since it must skip the hash entirely;
    // promiscuous next, which takes every other destination;
    // then the first wire bit splits logical from physical.
    // Swapping broadcast and promiscuous would give the same
    // answer today, but keeping broadcast apart leaves room for
    // a separate broadcast counter later.
    // Filter decision, pure combinational
    reg [31:0] crc_w; // CRC of incoming address
    reg [5:0] hash_idx; // Selected filter bit
    reg verdict; // Accept decision
    always @* begin
        crc_w = crc_of(da_addr);
        // Top six bits of the wire-order CRC, reflected register
        hash_idx = {crc_w[0], crc_w[1], crc_w[2],
                    crc_w[3], crc_w[4], crc_w[5]}; // R9
        if (da_addr == 48'hFFFFFFFFFFFF) begin
            // Broadcast never consults the hash
            verdict = ~mode_control_register[`IBAF_MODE_DISBC] |
                      mode_control_register[`IBAF_MODE_PROM]; // R11
        end else if (mode_control_register[`IBAF_MODE_PROM]) begin
            verdict = 1'b1; // Promiscuous takes everything
        end else if (da_addr[0]) begin
            // Logical; all-zero filter rejects all
            verdict = multicast_hash_filter[hash_idx]; // R8 R10
        end else begin
            verdict = (da_addr == station_address); // R8 R14
        end
    end

    // The fetch reads twelve 16-bit words, one per acknowledge.
    // The request stays high for the whole block; memory answers
    // at its own pace, so no cycle count is assumed anywhere.
    // A new INIT is only honoured while idle: an INIT bit written during a
    // fetch is dropped rather than restarting half way, which
    // would leave a mix of old and new fields.
    // Length register writes share this process because they
    // overwrite the same entry counts the fetch produces; one
    // process keeps one driver per register.
    // Fetch machine and configuration latches
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
            word_reg <= 4'h0;
            mem_addr <= 24'h000000;
            mem_req <= 1'b0;
            init_done <= 1'b0;
            mode_control_register <= `IBAF_MODE_RST;
            station_address <= 48'h000000000000;
            multicast_hash_filter <= 64'h0000000000000000;
            rx_ring_base <= 24'h000000;
            tx_ring_base <= 24'h000000;
            rx_ring_size_code <= 3'h0;
            tx_ring_size_code <= 3'h0;
            rx_ring_entries <= `IBAF_LEN_RST;
            tx_ring_entries <= `IBAF_LEN_RST;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (wr_pend_reg &&
                        wr_addr_reg == `IBAF_CTRL_OFF &&
                        hwdata[`IBAF_CTRL_INIT]) begin
                        // Base bit 0 ignored: word aligned only
                        mem_addr <= {cfg_base_reg[23:1], 1'b0}; // R1
                        word_reg <= 4'h0;
                        init_done <= 1'b0;
                        mem_req <= 1'b1;
                        state_reg <= S_REQ;
                    end
                end
                S_REQ: begin
                    if (mem_ack) begin
                        case (word_reg) // R2
                            `IBAF_CB_MODE:
                                mode_control_register <= mem_rdata; // R15
                            `IBAF_CB_RXLO:
                                rx_ring_base[15:0] <= mem_rdata; // R6
                            `IBAF_CB_RXHI: begin
                                rx_ring_base[23:16] <= mem_rdata[7:0]; // R6
                                rx_ring_size_code <= mem_rdata[
                                    `IBAF_SIZE_HI:`IBAF_SIZE_LO]; // R3
                                rx_ring_entries <= ent_of(mem_rdata[
                                    `IBAF_SIZE_HI:`IBAF_SIZE_LO]); // R4
                            end
                            `IBAF_CB_TXLO:
                                tx_ring_base[15:0] <= mem_rdata; // R6
                            `IBAF_CB_TXHI: begin
                                tx_ring_base[23:16] <= mem_rdata[7:0]; // R6
                                tx_ring_size_code <= mem_rdata[
                                    `IBAF_SIZE_HI:`IBAF_SIZE_LO]; // R3
                                tx_ring_entries <= ent_of(mem_rdata[
                                    `IBAF_SIZE_HI:`IBAF_SIZE_LO]); // R4
                            end
                            default: begin
                                // Station words 1..3, hash words 4..7
                                if (word_reg <= `IBAF_CB_STA2)
                                    station_address[(word_reg - 4'h1)*16
                                        +: 16] <= mem_rdata; // R13 R14
                                else
                                    multicast_hash_filter[(word_reg -
                                        `IBAF_CB_HASH0)*16 +: 16]
                                        <= mem_rdata;
                            end
                        endcase
                        if (word_reg == `IBAF_CB_WORDS - 4'h1) begin
                            mem_req <= 1'b0;
                            state_reg <= S_DONE;
                        end else begin
                            word_reg <= word_reg + 4'h1; // R17
                            mem_addr <= mem_addr + 24'h000002;
                        end
                    end
                end
                S_DONE: begin
                    init_done <= 1'b1; // R17
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
            // Length registers only take effect once setup is done
            if (wr_pend_reg && init_done && state_reg == S_IDLE) begin
                if (wr_addr_reg == `IBAF_RX_LEN_OFF)
                    rx_ring_entries <= hwdata[7:0]; // R5
                if (wr_addr_reg == `IBAF_TX_LEN_OFF)
                    tx_ring_entries <= hwdata[7:0]; // R5
            end
        end
    end

    // Enables follow the run bit, but never ahead of a complete
    // setup. The extra register stage costs one cycle of latency
    // and keeps the enables glitch free when init restarts.
    // Reception and transmission gated by a finished setup
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_enable <= 1'b0;
            tx_enable <= 1'b0;
        end else begin
            rx_enable <= run_reg & init_done; // R17
            tx_enable <= run_reg & init_done; // R17
        end
    end

    // The verdict is a registered output, so the caller sees it
    // exactly one cycle after presenting the address. The last
    // address and result are kept for software to read back,
    // which helps when chasing an unexpected rejection.
    // Accept holds between strobes; only valid is a pulse.
    // Filter verdict registered one cycle after the strobe
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_valid <= 1'b0;
            filt_accept <= 1'b0;
            last_da_reg <= 48'h000000000000;
            last_res_reg <= 1'b0;
        end else begin
            filt_valid <= da_valid;
            if (da_valid) begin
                filt_accept <= verdict;
                last_da_reg <= da_addr;
                last_res_reg <= verdict;
            end
        end
    end

    // Writes arrive in two phases: the offset comes with the
    // address phase and the data one cycle later. Only the low
    // byte of the offset is decoded; higher bits alias, which
    // saves comparators since the slave window is small.
    // Unmapped offsets are silently ignored.
    // AHB write side: address phase latched, data applied next cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            cfg_base_reg <= 24'h000000;
            run_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_take;
            if (wr_take)
                wr_addr_reg <= haddr[7:0];
            if (wr_pend_reg) begin
                if (wr_addr_reg == `IBAF_CFG_BASE_OFF)
                    cfg_base_reg <= hwdata[23:0];
                if (wr_addr_reg == `IBAF_CTRL_OFF)
                    run_reg <= hwdata[`IBAF_CTRL_RUN];
            end
        end
    end

    // Read data is captured at the address phase edge, so it
    // already stands when the master samples the data phase.
    // That is what lets hreadyout stay tied high. The cost is
    // that a value changing in the same cycle is seen one cycle
    // old, which software polling status never notices.
    // Unused upper bits read as zero.
    // AHB read side: data registered at the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_take) begin
            case (haddr[7:0])
                `IBAF_CTRL_OFF: hrdata <= {30'h0, run_reg, 1'b0};
                `IBAF_STATUS_OFF:
                    hrdata <= {26'h0, tx_ring_size_code,
                               init_done, rx_enable, tx_enable};
                `IBAF_CFG_BASE_OFF: hrdata <= {8'h00, cfg_base_reg};
                `IBAF_RX_LEN_OFF: hrdata <= {24'h0, rx_ring_entries};
                `IBAF_TX_LEN_OFF: hrdata <= {24'h0, tx_ring_entries};
                `IBAF_MODE_OFF: hrdata <= {16'h0, mode_control_register};
                `IBAF_RX_BASE_OFF:
                    hrdata <= {5'h00, rx_ring_size_code, rx_ring_base};
                `IBAF_TX_BASE_OFF:
                    hrdata <= {5'h00, tx_ring_size_code, tx_ring_base};
                `IBAF_STA_LO_OFF: hrdata <= station_address[31:0];
                `IBAF_STA_HI_OFF:
                    hrdata <= {16'h0, station_address[47:32]};
                `IBAF_HASH_LO_OFF: hrdata <= multicast_hash_filter[31:0];
                `IBAF_HASH_HI_OFF:
                    hrdata <= multicast_hash_filter[63:32];
                `IBAF_FILT_DA_LO_OFF: hrdata <= last_da_reg[31:0];
                `IBAF_FILT_DA_HI_OFF: hrdata <= {16'h0, last_da_reg[47:32]};
                `IBAF_FILT_RES_OFF: hrdata <= {31'h0, last_res_reg};
                default: hrdata <= 32'h00000000; // Unmapped reads zero
            endcase
        end
    end
endmodule // ibaf_top

/* test/ibaf_checker.sv */
`timescale 1ns/1ps
`include "ibaf_map.vh"
module ibaf_checker (
    input wire hclk, // Bus clock
    input wire hresetn, // Async reset, low
    input wire hreadyout, // Slave ready
    input wire hresp, // Response
    input wire [23:0] mem_addr, // Fetch address
    input wire mem_req, // Fetch request
    input wire mem_ack, // Word returned
    input wire init_done, // Setup loaded
    input wire rx_enable, // Receive on
    input wire tx_enable, // Transmit on
    input wire [15:0] mode_control_register, // Mode copy
    input wire [47:0] station_address, // Node address
    input wire da_valid, // Destination strobe
    input wire [47:0] da_addr, // Destination
    input wire filt_valid, // Verdict strobe
    input wire filt_accept // Verdict
);
    wire bc; // All-ones destination
    wire prom; // Promiscuous mode
    wire nobc; // Broadcast disabled
    assign bc = &da_addr;
    assign prom = mode_control_register[`IBAF_MODE_PROM];
    assign nobc = mode_control_register[`IBAF_MODE_DISBC];
    // Single domain, so one default clock and disable
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("Bus slave not ready or not OKAY");
    a_verdict_one_late: assert property (filt_valid == $past(da_valid))
        else $error("Verdict strobe not one cycle after request");
    a_fetch_addr_step: assert property (mem_req && mem_ack |=>
        !mem_req || mem_addr == $past(mem_addr) + 24'h000002)
        else $error("Fetch address not ascending by one word");
    a_done_after_fetch: assert property ($rose(init_done) |-> !mem_req &&
        ($past(mem_ack, 2) || $past(mem_ack, 3)))
        else $error("Setup flagged done away from last word");
    a_enable_after_done: assert property (rx_enable || tx_enable |->
        $past(init_done))
        else $error("Enable without completed setup");
    a_bcast_accept: assert property (da_valid && bc && !nobc |=> filt_accept)
        else $error("Broadcast rejected while enabled");
    a_bcast_reject: assert property (da_valid && bc && nobc && !prom
        |=> !filt_accept)
        else $error("Broadcast accepted while disabled");
    a_prom_accept: assert property (da_valid && prom |=> filt_accept)
        else $error("Promiscuous frame rejected");
    a_phys_compare: assert property (da_valid && !da_addr[0] && !prom |=>
        filt_accept == ($past(da_addr) == station_address))
        else $error("Physical verdict differs from address match");
endmodule // ibaf_checker
bind ibaf_top ibaf_checker u_ibaf_checker (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .mem_addr(mem_addr),
    .mem_req(mem_req), .mem_ack(mem_ack), .init_done(init_done),
    .rx_enable(rx_enable), .tx_enable(tx_enable),
    .mode_control_register(mode_control_register),
    .station_address(station_address), .da_valid(da_valid),
    .da_addr(da_addr), .filt_valid(filt_valid), .filt_accept(filt_accept));

/* test/ibaf_mem.sv */
`timescale 1ns/1ps
module ibaf_mem #(parameter logic [23:0] BASE = 24'h000100) (
    input wire hclk, // Clock
    input wire hresetn, // Async reset, low
    input wire [23:0] mem_addr, // Fetch address
    input wire mem_req, // Fetch request
    output logic mem_ack, // Word returned
    output logic [15:0] mem_rdata // Word
);
    logic [15:0] words [0:11]; // Config block image, word aligned
    logic [23:0] idx; // Word index in block
    logic [1:0] cnt; // Wait cycles so far
    assign idx = (mem_addr - BASE) >> 1;
    // Odd double words answer slowly; idle data toggles so no stale word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'hA5A5;
            cnt <= 2'h0;
        end else if (mem_req && !mem_ack &&
                     cnt >= (mem_addr[2] ? 2'h3 : 2'h0)) begin
            mem_ack <= 1'b1;
            mem_rdata <= words[idx[3:0]];
            cnt <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= mem_req ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule // ibaf_mem

/* test/ibaf_top_tb.sv */
`timescale 1ns/1ps
`include "ibaf_map.vh"
module ibaf_top_tb;
    logic hclk, hresetn, hsel, hwrite, da_valid; // Driven inputs
    logic [31:0] haddr, hwdata, hrdata, rd; // Bus data
    logic [1:0] htrans; // Transfer type
    logic [2:0] hsize; // Word size
    logic hreadyout, hresp, mem_req, mem_ack, init_done; // Status
    logic rx_enable, tx_enable, filt_valid, filt_accept; // Status
    logic [23:0] mem_addr, rx_ring_base, tx_ring_base; // Addresses
    logic [15:0] mem_rdata, mode_control_register; // Words
    logic [47:0] station_address, da_addr; // Node addresses
    logic [7:0] rx_ring_entries, tx_ring_entries; // Ring lengths
    integer n_errors = 0;
    integer checks_done = 0;
    localparam logic [47:0] STA = 48'h0A0B0C0D0E02; // Individual
    localparam logic [47:0] MC1 = 48'h0102035E0001; // Group address
    localparam logic [47:0] MC2 = 48'h0A0908070603; // Group address
    localparam logic [47:0] BCAST = 48'hFFFFFFFFFFFF; // Broadcast
    ibaf_top u_ibaf_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mem_addr(mem_addr),
        .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .init_done(init_done), .rx_enable(rx_enable), .tx_enable(tx_enable),
        .mode_control_register(mode_control_register),
        .station_address(station_address), .rx_ring_base(rx_ring_base),
        .tx_ring_base(tx_ring_base), .rx_ring_entries(rx_ring_entries),
        .tx_ring_entries(tx_ring_entries), .da_valid(da_valid),
        .da_addr(da_addr), .filt_valid(filt_valid), .filt_accept(filt_accept));
    ibaf_mem u_ibaf_mem (.hclk(hclk), .hresetn(hresetn), .mem_addr(mem_addr),
        .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // Free running clock, 5 ns
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hash index kept independent of the design: reflected CRC, LSB first
    function logic [5:0] hidx(input logic [47:0] d);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? `IBAF_CRC_POLY : 32'h0);
        hidx = {c[0], c[1], c[2], c[3], c[4], c[5]};
    endfunction
    // Single AHB-Lite transfer; waits on hready in both phases
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (hreadyout !== 1'b1) n_errors++;
        htrans <= 2'h0; hwdata <= d;
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (hreadyout !== 1'b1) n_errors++;
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task filt(input logic [47:0] da, input logic exp);
        @(posedge hclk);
        da_valid <= 1'b1; da_addr <= da;
        @(posedge hclk);
        da_valid <= 1'b0;
        #1;
        check(filt_valid, 1'b1);
        check(filt_accept, exp);
    endtask
    // Loads the block image, starts the fetch and checks every field except the hash filter
    task load(input logic [15:0] mode, input logic [63:0] hash);
        for (int i = 0; i < 3; i++) u_ibaf_mem.words[1 + i] = STA[16 * i +: 16];
        for (int i = 0; i < 4; i++) u_ibaf_mem.words[4 + i] = hash[16 * i +: 16];
        u_ibaf_mem.words[0] = mode;
        u_ibaf_mem.words[8] = 16'h3450; // Rx base low, 8-byte aligned
        u_ibaf_mem.words[9] = 16'hE012; // Rx code 111, base high
        u_ibaf_mem.words[10] = 16'hABC8; // Tx base low
        u_ibaf_mem.words[11] = 16'h0000; // Tx code 000
        bus(1'b1, `IBAF_CFG_BASE_OFF, 32'h00000100);
        bus(1'b1, `IBAF_CTRL_OFF, 32'h00000001);
        for (int i = 0; i < 20 && mem_req !== 1'b1; i++) @(posedge hclk);
        for (int i = 0; i < 300 && init_done !== 1'b1; i++) @(posedge hclk);
        #1;
        check(init_done, 1'b1);
        check(mode_control_register, mode);
        check(station_address, STA);
        check(rx_ring_base, 24'h123450);
        check(tx_ring_base, 24'h00ABC8);
        check(rx_ring_entries, 8'h80);
        check(tx_ring_entries, 8'h01);
    endtask
    // Mode with transmit CRC off; no group hash bits; physical and broadcast
    task t_plain;
        load(16'h0008, 64'h0);
        filt(STA, 1'b1);
        filt(STA ^ 48'h000000000100, 1'b0);
        filt(MC1, 1'b0);
        filt(BCAST, 1'b1);
    endtask
    // Length writes refused before setup, used after; status and reads
    task t_regs;
        bus(1'b1, `IBAF_TX_LEN_OFF, 32'h00000009);
        #1 check(tx_ring_entries, 8'h01);
        t_plain;
        bus(1'b1, `IBAF_RX_LEN_OFF, 32'h00000005);
        @(posedge hclk);
        #1 check(rx_ring_entries, 8'h05);
        bus(1'b1, `IBAF_CTRL_OFF, 32'h00000002);
        repeat (2) @(posedge hclk);
        bus(1'b0, `IBAF_STATUS_OFF, 32'h0);
        check(rd, 32'h00000007);
        bus(1'b0, `IBAF_RX_BASE_OFF, 32'h0);
        check(rd, 32'h07123450);
        bus(1'b0, `IBAF_MODE_OFF, 32'h0);
        check(rd, 32'h00000008);
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h00000000);
    endtask
    // Broadcast disabled with one hash bit, then promiscuous
    task t_hash_prom;
        load(16'h4000, 64'h1 << hidx(MC1));
        filt(BCAST, 1'b0);
        filt(MC1, 1'b1);
        filt(MC2, hidx(MC2) == hidx(MC1));
        load(16'hC000, 64'h0);
        filt(BCAST, 1'b1);
        filt(MC2, 1'b1);
        filt(STA ^ 48'h000000000100, 1'b1);
    endtask
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        da_valid = 1'b0; da_addr = 48'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check(mode_control_register, `IBAF_MODE_RST);
        check(init_done, 1'b0);
        t_regs;
        t_hash_prom;
        give_verdict;
    end
    // Watchdog well beyond the few hundred cycles needed
    initial begin
        #50000;
        n_errors++;
        give_verdict;
    end
endmodule // ibaf_top_tb
